// >>> src/prd_pkg.sv
// Package: constants and carrier types of the processor register datapath
package prd_pkg;
  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int WORD_W = 24;        // Memory word
  localparam int ADDR_W = 16;        // Memory word pointer
  localparam int OPC_W  = 8;         // Opcode holder
  localparam int IDX_W  = 18;        // Index register
  localparam int IOA_W  = 14;        // Transfer control address lines
  localparam int N_TCW  = 4;         // Transfer control registers
  localparam int N_IDX  = 3;         // Index registers
  localparam int N_CHAN = 8;         // Four in, four out
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS       = 50;
  localparam int MEM_CYC_NS   = 750;
  localparam int INSTR_MIN_NS = 750;
  localparam int INSTR_MAX_NS = 2250;
  localparam int MEM_CYC_CLKS = (MEM_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int INSTR_MIN_CLKS = (INSTR_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int INSTR_MAX_CLKS = INSTR_MAX_NS / CLK_NS;
  localparam logic [3:0] STEP_LAST = 4'(MEM_CYC_CLKS - 1);
  // ************************************************************
  // Memory size
  // ************************************************************
  localparam int MEM_WORDS_MIN = 8192;
  localparam int MEM_WORDS_INC = 8192;
  localparam int MEM_WORDS_MAX = 65536;
  localparam int MEM_WORDS     = MEM_WORDS_MIN;  // Installed size
  localparam logic [ADDR_W-1:0] MEM_MASK = ADDR_W'(MEM_WORDS - 1);
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FN_HI = 23;   // Function code
  localparam int FN_LO = 18;
  localparam int IND_BIT = 17; // Indirect designator
  localparam int IX_HI = 16;   // Index designator
  localparam int IX_LO = 15;
  localparam int Y_HI  = 14;   // Operand address
  localparam int OPC_LO = 16;  // Low bit of opcode holder copy
  localparam int CNT_HI = 23;  // Transfer control word count
  localparam int CNT_LO = 16;
  localparam int TA_HI  = 15;  // Transfer control word address
  // ************************************************************
  // Register offsets and reset values
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_INSTRUCTION_COUNTER = 16'h0000;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HOLDER       = 16'h0001;
  localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
  localparam logic [WORD_W-1:0] RST_WORD = 24'h000000;
  // ************************************************************
  // Function codes and panel selects
  // ************************************************************
  localparam logic [5:0] OP_STOP  = 6'h00;
  localparam logic [5:0] OP_JUMP  = 6'h07;
  localparam logic [5:0] OP_ADD   = 6'h08;
  localparam logic [5:0] OP_SUB   = 6'h09;
  localparam logic [5:0] OP_AND   = 6'h0a;
  localparam logic [5:0] OP_XOR   = 6'h0b;
  localparam logic [5:0] OP_LDIX  = 6'h0d;
  localparam logic [5:0] OP_LDA   = 6'h0e;
  localparam logic [5:0] OP_STA   = 6'h12;
  localparam logic [5:0] OP_LDK   = 6'h1a;
  localparam logic [5:0] OP_LDTCW = 6'h1c;
  localparam logic [1:0] PNL_S = 2'h0;
  localparam logic [1:0] PNL_Z = 2'h1;
  localparam logic [1:0] PNL_A = 2'h2;
  localparam logic [1:0] PNL_P = 2'h3;
  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } prd_mem_t;
  typedef struct packed {
    logic              req;
    logic [2:0]        chan;      // Bit 2 high: output channel
    logic              mem_tcw;   // Control word kept in core
    logic [IOA_W-1:0]  tcw_addr;
    logic [WORD_W-1:0] wdata;
  } prd_io_t;
  typedef enum logic [2:0] {
    ST_STOP, ST_FETCH, ST_IND, ST_OPER, ST_IO
  } prd_state_t;
endpackage

// >>> src/prd_datapath.sv
// Module: register set, datapath and buffered channel control
// Contract
// - Memory word pointer is sixteen bits
// - Pointer shown; altered only when stopped
// - Fetched word holder captures memory read
// - Adder sums auxiliary addend and input latch
// - Opcode holder keeps codes through execution
// - Output holder keeps data for slow peripheral
// - Operand address one selects result holder
// - Some operations use result holder implicitly
// - Operand address zero selects instruction counter
// - Instruction counter increments, addresses each fetch
// - Adder input latch loads index registers
// - Four transfer control registers outside memory
// - Transfer control words may sit in memory
// - Four input, four output 24-bit channels
// - Fourteen lines name transfer control address
// - Channel word takes one to three cycles
// - Instruction takes 0.75 to 2.25 microseconds
// - Memory 8192 to 65536 words, 8192 steps
// - Arithmetic is two's complement addition
// - Instruction word: function, indirect, index, address
// - Three index registers added to address
`timescale 1ns/100ps
module prd_datapath
  import prd_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              start,
  input  wire logic [WORD_W-1:0] mem_rdata,
  output prd_mem_t               mem,
  input  wire prd_io_t           io,
  output logic                   io_ack,
  output logic [WORD_W-1:0]      out_data,
  output logic                   out_valid,
  input  wire logic              out_taken,
  input  wire logic [1:0]        panel_sel,
  input  wire logic              panel_wr,
  input  wire logic [WORD_W-1:0] panel_data,
  output logic [WORD_W-1:0]      panel_disp,
  output logic [OPC_W-1:0]       panel_func,
  output logic                   running
);
  // ************************************************************
  // State and registers
  // ************************************************************
  prd_state_t        state;           // Current sequence
  prd_state_t        next_state;      // Sequence after this edge
  logic [3:0]        step;            // Clock within memory cycle
  logic [1:0]        ph;              // Channel transfer phase
  prd_io_t           io_q;            // Request being served
  logic              seq_rd;          // Current cycle is a read
  logic [WORD_W-1:0] z;               // Fetched word holder
  logic [WORD_W-1:0] x;               // Auxiliary addend
  logic [WORD_W-1:0] d;               // Adder input latch
  logic [WORD_W-1:0] acc;             // Result holder
  logic [WORD_W-1:0] iow;             // Working control word
  logic [OPC_W-1:0]  f;               // Opcode holder
  logic [ADDR_W-1:0] pc;              // Instruction counter
  logic [ADDR_W-1:0] ea;              // Effective operand address
  logic [1:0]        bsel;            // Index designator held
  logic              add_go;          // Adder result due
  logic              idx_go;          // Index load due
  logic [6:0]        ic;              // Clocks in this instruction
  logic [IDX_W-1:0]  idx [N_IDX+1];   // Entry 0 reads as zero
  logic [WORD_W-1:0] tcw [N_TCW];     // Transfer control registers
  logic [ADDR_W-1:0] n_addr;          // Launch address
  logic              n_rd;            // Launch read
  logic              n_wr;            // Launch write
  logic [WORD_W-1:0] n_wd;            // Launch write data
  // ************************************************************
  // Decode
  // ************************************************************
  wire in_ftch = state == ST_FETCH;
  wire seq_end = ce && state != ST_STOP && step == STEP_LAST;
  wire [1:0] rd_b = mem_rdata[IX_HI:IX_LO];
  wire [ADDR_W-1:0] rd_ea =
    {1'b0, mem_rdata[Y_HI:0]} + idx[rd_b][ADDR_W-1:0];
  wire [5:0] cur_op = in_ftch ? mem_rdata[FN_HI:FN_LO]
                              : f[OPC_W-1:2];
  wire cur_i = in_ftch && mem_rdata[IND_BIT];
  wire [ADDR_W-1:0] cur_ea = state == ST_OPER ? ea : rd_ea;
  wire ea_pc  = cur_ea == OFS_INSTRUCTION_COUNTER;
  wire ea_acc = cur_ea == OFS_RESULT_HOLDER;
  wire mem_op = cur_op == OP_ADD || cur_op == OP_SUB ||
                cur_op == OP_AND || cur_op == OP_XOR ||
                cur_op == OP_LDA || cur_op == OP_STA ||
                cur_op == OP_LDIX;
  wire need_mem = mem_op && !ea_pc && !ea_acc;
  // Register operands bypass memory entirely
  wire [WORD_W-1:0] opnd = ea_pc  ? {8'h00, pc} :
                           ea_acc ? acc : mem_rdata;
  wire exec_now = seq_end && (state == ST_OPER ||
    ((in_ftch || state == ST_IND) && !cur_i && !need_mem));
  wire halt = exec_now && cur_op == OP_STOP;
  wire to_pc = exec_now && (cur_op == OP_JUMP ||
                            (cur_op == OP_STA && ea_pc));
  wire [ADDR_W-1:0] pc_now = !to_pc ? pc :
    cur_op == OP_JUMP ? cur_ea : acc[ADDR_W-1:0];
  // Output channel refused while the output holder is full
  wire io_ok = io.req && !(io.chan[2] && out_valid);
  wire [WORD_W-1:0] iow_next = {iow[CNT_HI:CNT_LO] - 8'h01,
                                iow[TA_HI:0] + 16'h0001};
  wire io_last = iow_next[CNT_HI:CNT_LO] == 8'h00;
  wire io_done = seq_end && state == ST_IO && (ph == 2'h2 ||
    (ph == 2'h1 && (!io_q.mem_tcw || io_last)));
  wire tcw_upd = seq_end && state == ST_IO && ph == 2'h1 &&
                 !io_q.mem_tcw;
  wire io_data = seq_end && state == ST_IO && ph == 2'h1;
  wire pnl_ok = ce && state == ST_STOP && !running && panel_wr;
  prd_state_t after;
  assign after = io_ok ? ST_IO : (running && !halt) ? ST_FETCH
                                                  : ST_STOP;
  wire launch = next_state != ST_STOP &&
                (state == ST_STOP || seq_end);
  assign idx[0] = '0;
  // ************************************************************
  // Sequencing
  // ************************************************************
  // Next sequence from the end of the current one
  always_comb begin
    next_state = state;
    case (state)
      ST_STOP: begin
        if (ce && io_ok) next_state = ST_IO;
        else if (ce && start) next_state = ST_FETCH;
      end
      ST_FETCH: begin
        if (seq_end) next_state = cur_i ? ST_IND :
                                  need_mem ? ST_OPER : after;
      end
      ST_IND: begin
        if (seq_end) next_state = need_mem ? ST_OPER : after;
      end
      ST_OPER: begin
        if (seq_end) next_state = after;
      end
      ST_IO: begin
        if (io_done) next_state = running ? ST_FETCH : ST_STOP;
      end
      default: next_state = ST_STOP;
    endcase
  end
  // Memory request for the sequence being launched
  always_comb begin
    n_addr = pc_now;
    n_rd   = 1'b1;
    n_wr   = 1'b0;
    n_wd   = acc;
    case (next_state)
      ST_IND: n_addr = rd_ea;
      ST_OPER: begin
        n_addr = cur_ea;
        n_rd   = cur_op != OP_STA;
        n_wr   = cur_op == OP_STA;
      end
      ST_IO: begin
        if (state != ST_IO && io.mem_tcw) begin
          n_addr = {2'b00, io.tcw_addr};
        end else if (state != ST_IO) begin
          n_addr = tcw[io.chan[1:0]][TA_HI:0];
          n_rd   = io.chan[2];
          n_wr   = !io.chan[2];
          n_wd   = io.wdata;
        end else if (ph == 2'h0) begin
          n_addr = mem_rdata[TA_HI:0];
          n_rd   = io_q.chan[2];
          n_wr   = !io_q.chan[2];
          n_wd   = io_q.wdata;
        end else begin
          n_addr = {2'b00, io_q.tcw_addr};
          n_rd   = 1'b0;
          n_wr   = 1'b1;
          n_wd   = iow_next;
        end
      end
      default: n_addr = pc_now;
    endcase
  end
  // Sequence state, step count and run flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state   <= ST_STOP;
      step    <= 4'h0;
      running <= 1'b0;
      ph      <= 2'h0;
      seq_rd  <= 1'b0;
      ic      <= 7'h00;
    end else if (ce) begin
      state <= next_state;
      step  <= launch ? 4'h0 : step + 4'h1;
      if (state == ST_STOP && next_state == ST_FETCH) running <= 1'b1;
      else if (halt) running <= 1'b0;
      if (launch) seq_rd <= n_rd;
      if (launch && state != ST_IO) ph <= io.mem_tcw ? 2'h0 : 2'h1;
      else if (launch) ph <= ph + 2'h1;
      if (launch && next_state == ST_FETCH) ic <= 7'h00;
      else if (state != ST_STOP && state != ST_IO) ic <= ic + 7'h01;
    end
  end
  // Memory word pointer and request strobes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem <= '0;
    end else if (ce) begin
      mem.rd <= launch && n_rd;
      mem.wr <= launch && n_wr;
      if (launch) begin
        mem.addr  <= n_addr & MEM_MASK;
        mem.wdata <= n_wd;
      end else if (pnl_ok && panel_sel == PNL_S) begin
        mem.addr <= panel_data[ADDR_W-1:0] & MEM_MASK;
      end
    end
  end
  // ************************************************************
  // Datapath registers
  // ************************************************************
  // Fetched word, opcode holder, address and index designator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      z    <= RST_WORD;
      f    <= '0;
      ea   <= RST_ADDR;
      bsel <= 2'h0;
    end else if (ce) begin
      if (seq_end && seq_rd) z <= mem_rdata;
      else if (pnl_ok && panel_sel == PNL_Z) z <= panel_data;
      if (seq_end && in_ftch) begin
        f    <= mem_rdata[WORD_W-1:OPC_LO];
        bsel <= rd_b;
      end
      if (seq_end && (in_ftch || state == ST_IND)) ea <= rd_ea;
    end
  end
  // Instruction counter
  always_ff @(posedge ref_clk) begin
    if (rst) pc <= RST_ADDR;
    else if (ce && launch && next_state == ST_FETCH)
      pc <= pc_now + 16'h0001;
    else if (ce && to_pc) pc <= pc_now;
    else if (pnl_ok && panel_sel == PNL_P)
      pc <= panel_data[ADDR_W-1:0];
  end
  // Result holder, addend and adder input latch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc    <= RST_WORD;
      x      <= RST_WORD;
      d      <= RST_WORD;
      add_go <= 1'b0;
      idx_go <= 1'b0;
    end else if (ce) begin
      add_go <= exec_now && (cur_op == OP_ADD || cur_op == OP_SUB);
      idx_go <= exec_now && cur_op == OP_LDIX;
      if (exec_now && (cur_op == OP_ADD || cur_op == OP_SUB)) begin
        x <= acc;
        d <= cur_op == OP_SUB ? ~opnd + 24'h000001 : opnd;
      end else if (exec_now && cur_op == OP_LDIX) begin
        d <= opnd;
      end
      if (add_go) acc <= x + d;
      else if (exec_now && cur_op == OP_AND) acc <= acc & opnd;
      else if (exec_now && cur_op == OP_XOR) acc <= acc ^ opnd;
      else if (exec_now && cur_op == OP_LDA) acc <= opnd;
      else if (exec_now && cur_op == OP_LDK) acc <= {8'h00, cur_ea};
      else if (pnl_ok && panel_sel == PNL_A) acc <= panel_data;
    end
  end
  // Index registers, loaded through the adder input latch
  for (genvar g = 1; g <= N_IDX; g++) begin : g_idx
    always_ff @(posedge ref_clk) begin
      if (rst) idx[g] <= '0;
      else if (ce && idx_go && bsel == 2'(g))
        idx[g] <= d[IDX_W-1:0];
    end
  end
  // Transfer control registers
  for (genvar g = 0; g < N_TCW; g++) begin : g_tcw
    always_ff @(posedge ref_clk) begin
      if (rst) tcw[g] <= RST_WORD;
      else if (ce && exec_now && cur_op == OP_LDTCW &&
               cur_ea[1:0] == 2'(g)) tcw[g] <= acc;
      else if (tcw_upd && io_q.chan[1:0] == 2'(g))
        tcw[g] <= iow_next;
    end
  end
  // ************************************************************
  // Channels and panel
  // ************************************************************
  // Request latch, working control word and output holder
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_q      <= '0;
      iow       <= RST_WORD;
      out_data  <= RST_WORD;
      out_valid <= 1'b0;
      io_ack    <= 1'b0;
    end else if (ce) begin
      io_ack <= io_done;
      if (launch && next_state == ST_IO && state != ST_IO) begin
        io_q <= io;
        iow  <= tcw[io.chan[1:0]];
      end else if (seq_end && state == ST_IO && ph == 2'h0) begin
        iow <= mem_rdata;
      end
      if (io_data && io_q.chan[2]) begin
        out_data  <= mem_rdata;
        out_valid <= 1'b1;
      end else if (out_taken) begin
        out_valid <= 1'b0;
      end
    end
  end
  // Operator panel display
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      panel_disp <= RST_WORD;
      panel_func <= '0;
    end else if (ce) begin
      panel_func <= f;
      case (panel_sel)
        PNL_S:   panel_disp <= {8'h00, mem.addr};
        PNL_Z:   panel_disp <= z;
        PNL_A:   panel_disp <= acc;
        default: panel_disp <= {8'h00, pc};
      endcase
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_addr_in_mem: assert property (mem.addr <= MEM_MASK)
    else $error("pointer outside installed memory");
  a_pc_step: assert property (ce && launch &&
    next_state == ST_FETCH |=> pc == mem.addr + 16'h0001)
    else $error("counter not one past fetch address");
  a_z_capture: assert property (seq_end && seq_rd
    |=> z == $past(mem_rdata)) else $error("word not captured");
  a_f_upper: assert property (seq_end && in_ftch
    |=> f == $past(mem_rdata[WORD_W-1:OPC_LO]))
    else $error("opcode holder not loaded");
  a_add_sum: assert property (ce && add_go
    |=> acc == $past(x + d)) else $error("bad adder result");
  a_panel_lock: assert property (ce && running && panel_wr &&
    !launch |=> $stable(mem.addr)) else $error("pointer altered");
  a_instr_time: assert property (ic < 7'(INSTR_MAX_CLKS))
    else $error("instruction too long");
  a_out_hold: assert property (ce && out_valid && !out_taken
    |=> out_valid && $stable(out_data)) else $error("output lost");
  a_acc_opnd: assert property (exec_now && cur_op == OP_LDA &&
    ea_pc |=> acc == {8'h00, $past(pc)}) else $error("bad counter read");
  a_ded_xfer: assert property (ce && launch && state == ST_STOP &&
    next_state == ST_IO && !io.mem_tcw |-> ##[1:16] io_ack)
    else $error("dedicated transfer too slow");
  c_add: cover property (add_go);
  c_io_three: cover property (state == ST_IO && ph == 2'h2);
  c_halt: cover property (halt);
  c_out_take: cover property (out_valid && out_taken);
endmodule

// >>> tb/prd_mem_model.sv
// Core memory model facing the datapath memory port
`timescale 1ns/100ps
module prd_mem_model
  import prd_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire prd_mem_t      mem,
  output logic [WORD_W-1:0]  mem_rdata
);
  logic [WORD_W-1:0] words [MEM_WORDS];  // Installed core words
  logic [3:0]        age;                // Cycles since read launch
  logic              open_rd;            // Read data window open
  initial begin
    age     = 4'h0;
    open_rd = 1'b0;
  end
  // Valid word only inside the read window, scrambled outside it
  assign mem_rdata = open_rd ? words[mem.addr[12:0]]
                             : ~words[mem.addr[12:0]];
  // Open a window per read pulse; a write lands at its pulse
  always @(posedge ref_clk) begin
    if (mem.rd) begin
      age     <= 4'h0;
      open_rd <= 1'b1;
    end else if (age == STEP_LAST) begin
      open_rd <= 1'b0;
    end else begin
      age <= age + 4'h1;
    end
    if (mem.wr) begin
      words[mem.addr[12:0]] <= mem.wdata;
    end
  end
endmodule

// >>> tb/processor_register_datapath_tb_top.sv
// Self-checking bench for the register datapath
`timescale 1ns/100ps
module processor_register_datapath_tb_top;
  import prd_pkg::*;
  logic ref_clk = 0, rst = 1, ce = 1, start = 0;
  logic out_taken = 0, panel_wr = 0, io_ack, out_valid, running;
  logic [1:0]        panel_sel = 2'h0;   // Panel select
  logic [WORD_W-1:0] panel_data = '0, mem_rdata, out_data, panel_disp;
  logic [OPC_W-1:0]  panel_func;         // Opcode holder view
  prd_mem_t          mem;                // Memory request
  prd_io_t           io = '0;            // Channel request
  int                n_mismatch = 0, checks_done = 0;
  int                n;                  // Cycle counter
  always #25 ref_clk = ~ref_clk;
  prd_datapath prd_datapath_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .start(start), .mem_rdata(mem_rdata), .mem(mem), .io(io),
    .io_ack(io_ack), .out_data(out_data), .out_valid(out_valid),
    .out_taken(out_taken), .panel_sel(panel_sel), .panel_wr(panel_wr),
    .panel_data(panel_data), .panel_disp(panel_disp),
    .panel_func(panel_func), .running(running));
  prd_mem_model prd_mem_model_inst (.ref_clk(ref_clk), .mem(mem),
    .mem_rdata(mem_rdata));
  // ****
  // Shared tasks
  // ****
  task automatic cmp(string what, logic [WORD_W-1:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Panel access: optional write, then registered display
  task automatic panel(logic [1:0] s, logic w, logic [WORD_W-1:0] d);
    panel_sel  = s;
    panel_wr   = w;
    panel_data = d;
    step(1);
    panel_wr = 0;
    step(2);
  endtask
  // Preload one core word
  task automatic put(logic [15:0] a, logic [WORD_W-1:0] w);
    prd_mem_model_inst.words[a[12:0]] = w;
  endtask
  // Wait for the stop, bounded; running out of time ends the run
  task automatic wait_stop(int lim);
    while (running === 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    if (running !== 1'b0) begin
      n_mismatch++;
      summarize();
    end
  endtask
  function automatic logic [WORD_W-1:0] ins(logic [5:0] f, logic [14:0] y);
    return {f, 3'b000, y};
  endfunction
  // Channel transfer; m keeps the control word in core at 0x30
  task automatic xfer(logic [2:0] ch, logic m, int lo, int hi);
    io = '{1'b1, ch, m, 14'h0030, 24'habcdef};
    n  = 0;
    do begin
      step(1);
      n++;
      if (n > 200) begin
        n_mismatch++;
        summarize();
      end
    end while (io_ack !== 1'b1);
    io.req = 0;
    step(1);  // Let an edge pass before the next request
    cmp("transfer cycles", 1, 24'(n >= lo && n <= hi));
  endtask
  // ****
  // Scenarios
  // ****
  task automatic test_reset();
    cmp("running", 0, 24'(running));
    cmp("out_valid", 0, 24'(out_valid));
    cmp("opcode holder", 0, 24'(panel_func));
    panel(PNL_P, 1, 24'h000010);
    cmp("counter", 24'h000010, panel_disp);
    $display("reset and panel test done");
  endtask
  // Load, subtract, double via address one, store, stop
  task automatic test_program();
    prd_mem_model_inst.words[16'h10] = ins(OP_LDA, 15'h20);
    prd_mem_model_inst.words[16'h11] = ins(OP_SUB, 15'h21);
    prd_mem_model_inst.words[16'h12] = ins(OP_ADD, 15'h1);
    prd_mem_model_inst.words[16'h13] = ins(OP_STA, 15'h22);
    prd_mem_model_inst.words[16'h14] = ins(OP_STOP, 15'h0);
    prd_mem_model_inst.words[16'h20] = 24'h000003;
    prd_mem_model_inst.words[16'h21] = 24'h000007;
    start = 1;
    step(1);
    start = 0;
    step(20);
    cmp("running", 1, 24'(running));
    panel_sel  = PNL_S;  // Pointer write must be ignored while running
    panel_data = 24'h001fff;
    panel_wr   = 1;
    step(1);
    panel_wr = 0;
    n = 22;
    wait_stop(400);
    cmp("run time", 1, 24'(n >= 75 && n <= 225));
    step(2);
    cmp("stored", 24'hfffff8, prd_mem_model_inst.words[16'h22]);
    panel(PNL_A, 0, '0);
    cmp("result holder", 24'hfffff8, panel_disp);
    panel(PNL_P, 0, '0);
    cmp("counter", 24'h000015, panel_disp);
    $display("program test done");
  endtask
  task automatic test_channel();
    prd_mem_model_inst.words[16'h30] = {8'h02, 16'h0040};
    prd_mem_model_inst.words[16'h41] = 24'h123456;
    xfer(3'd0, 1, 40, 55);
    cmp("input word", 24'habcdef, prd_mem_model_inst.words[16'h40]);
    cmp("tcw", {8'h01, 16'h0041}, prd_mem_model_inst.words[16'h30]);
    xfer(3'd4, 1, 25, 39);
    cmp("out_data", 24'h123456, out_data);
    cmp("out_valid", 1, 24'(out_valid));
    cmp("tcw", {8'h01, 16'h0041}, prd_mem_model_inst.words[16'h30]);
    out_taken = 1;
    step(1);
    out_taken = 0;
    step(1);
    cmp("out_valid", 0, 24'(out_valid));
    $display("channel test done");
  endtask
  // Constant, control word load, index, indirect, logic ops, jump
  task automatic test_regs();
    put(16'h50, ins(OP_LDK, 15'h0070));
    put(16'h51, ins(OP_LDTCW, 15'h0004));
    put(16'h52, ins(OP_LDA, 15'h0000));  // Reads the counter
    put(16'h53, {OP_LDIX, 3'b001, 15'h0001});
    put(16'h54, {OP_LDA, 3'b101, 15'h000d});  // Indirect via index 1
    put(16'h55, ins(OP_XOR, 15'h0062));
    put(16'h56, ins(OP_JUMP, 15'h0058));
    put(16'h57, ins(OP_STOP, 15'h0000));  // Skipped by the jump
    put(16'h58, ins(OP_AND, 15'h0063));
    put(16'h59, {OP_STOP, 3'b010, 15'h0000});
    put(16'h60, 24'h000061);
    put(16'h61, 24'h0f0f0f);
    put(16'h62, 24'hffff00);
    put(16'h63, 24'h00ffff);
    ce = 0;  // Frozen: the panel write must not land
    panel(PNL_P, 1, 24'h000077);
    ce = 1;
    panel(PNL_P, 0, '0);
    cmp("frozen counter", 24'h000015, panel_disp);
    panel(PNL_P, 1, 24'h000050);
    start = 1;
    step(1);
    start = 0;
    n = 1;
    wait_stop(300);
    panel(PNL_A, 0, '0);
    cmp("result holder", 24'h00f00f, panel_disp);
    cmp("opcode holder", 24'h000001, 24'(panel_func));
    panel(PNL_P, 0, '0);
    cmp("counter", 24'h00005a, panel_disp);
    xfer(3'd0, 0, 12, 20);
    xfer(3'd0, 0, 12, 20);
    cmp("word 70", 24'habcdef, prd_mem_model_inst.words[16'h70]);
    cmp("word 71", 24'habcdef, prd_mem_model_inst.words[16'h71]);
    $display("register test done");
  endtask
  // Main sequence
  initial begin
    step(8);
    rst = 0;
    test_reset();
    test_program();
    test_channel();
    test_regs();
    summarize();
  end
endmodule
